/* hdl/hrs_pkg.sv */
// package for the hardware return stack: widths, opcodes, timing, carriers
package hrs_pkg;
  localparam int DEPTH = 8;
  localparam int WORD_W = 16;
  localparam int DMA_W = 7;
  localparam int ARP_W = 3;
  // opcode fields
  localparam logic [8:0] OPC_MEM_PUSH = 9'h0EC;
  localparam logic [15:0] OPC_ACC_PUSH = 16'hBE3C;
  localparam logic [15:0] OPC_RETURN = 16'hEF00;
  localparam logic [15:0] OPC_RETURN_DLY = 16'hFF00;
  localparam int IND_BIT = 7;
  // cycle counts and entry reset value
  localparam logic [2:0] RET_CYCLES = 3'h4;
  localparam logic [2:0] DLY_SLOTS = 3'h2;
  localparam logic [2:0] SINGLE_ACCESS_RAM_SAME_CYCLES = 3'h2;
  localparam logic [WORD_W-1:0] ENTRY_RESET = 16'h0000;

  typedef enum logic [2:0] {
    HRS_IDLE = 3'b000,
    HRS_MEM_WAIT = 3'b001,
    HRS_RET_FLUSH = 3'b010,
    HRS_RET_SLOT = 3'b011
  } hrs_state_t;

  // decoded operation handed to the stack array
  typedef struct packed {
    logic push;
    logic pop;
    logic [WORD_W-1:0] data;
  } hrs_op_t;

  // memory operand request toward the data-memory port
  typedef struct packed {
    logic req;
    logic indirect;
    logic [DMA_W-1:0] dma;
    logic arp_load;
    logic [ARP_W-1:0] aux_pointer_select;
  } hrs_mem_req_t;
endpackage

/* hdl/hrs_array.sv */
// eight-level shift stack storage with push and pop
`timescale 1ns/1ps
`default_nettype none
module hrs_array #(
  parameter int DEPTH = hrs_pkg::DEPTH,
  parameter int WORD_W = hrs_pkg::WORD_W
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // operation
  input wire hrs_pkg::hrs_op_t op,
  // state
  output logic [WORD_W-1:0] top
);
  logic [WORD_W-1:0] entry_reg [DEPTH];

  // each level shifts down on push and all but the deepest shift up on pop; no depth counter so
  // neither overflow nor underflow can be seen
  for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        entry_reg[i] <= hrs_pkg::ENTRY_RESET;
      end else if (clk_en) begin
        if (op.push) begin
          if (i == 0) begin
            entry_reg[i] <= op.data;
          end else begin
            entry_reg[i] <= entry_reg[i-1];
          end
        end else if (op.pop) begin
          if (i < DEPTH - 1) begin
            entry_reg[i] <= entry_reg[i+1];
          end // deepest keeps value
        end
      end
    end
  end

  assign top = entry_reg[0];
endmodule
`default_nettype wire

/* hdl/hardware_return_stack.sv */
// hardware return stack: decode, sequencing and program counter load
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - eight-entry last-in first-out stack, top is newest write.
// - pushes past eight discard oldest value, no overflow flag.
// - pushes come from push ops, calls, traps, interrupts and nmi.
// - memory push reads addressed word onto top after shifting down.
// - deepest entry is dropped on every push.
// - memory push takes 7-bit direct address or indirect with pointer.
// - memory push one cycle, two in shared single-access ram, 1+d external; here at least two cycles, three with shared ram.
// - accumulator push copies accumulator bits 15..0, accumulator untouched.
// - accumulator push shifts stack first, then writes top.
// - return loads program counter from top entry.
// - after loading, stack pops exactly one level.
// - delayed return runs next two words before taking effect.
// - plain return takes four cycles, discards two prefetched words.
// - on pop deepest entry keeps value, duplicated upward.
// - no underflow detection; deep pops return replicated value.
module hardware_return_stack #(
  parameter int WORD_W = hrs_pkg::WORD_W
) (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // instruction decoder
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic in_repeat,
  output logic instr_ready,
  output logic repeat_reject,
  // other stack users (call, trap, interrupt)
  input wire logic ext_push,
  input wire logic [WORD_W-1:0] ext_push_data,
  // accumulator
  input wire logic [31:0] acc,
  // data memory port
  output hrs_pkg::hrs_mem_req_t mem_req,
  input wire logic mem_same_single_access_ram,
  input wire logic mem_ready,
  input wire logic [WORD_W-1:0] mem_rdata,
  // program counter and stack top
  output logic pc_inc,
  output logic pc_load,
  output logic [WORD_W-1:0] pc_load_value,
  output logic fetch_discard,
  output logic [WORD_W-1:0] stack_top
);
  hrs_pkg::hrs_state_t state_reg;
  hrs_pkg::hrs_op_t op;
  logic [2:0] cnt_reg;
  logic dly_reg;
  logic [WORD_W-1:0] top;
  logic [WORD_W-1:0] pc_value_reg;
  logic pc_load_reg;
  logic pc_inc_reg;
  logic discard_reg;
  logic is_mpush;
  logic is_apush;
  logic is_ret;
  logic is_delayed_return_op;
  logic take;
  logic mem_done;

  // opcode decode
  // bit 7 picks direct or indirect, so only bits 15..8 name the memory push opcode
  assign is_mpush = instr_word[15:8] == hrs_pkg::OPC_MEM_PUSH[8:1];
  assign is_apush = instr_word == hrs_pkg::OPC_ACC_PUSH;
  assign is_ret = instr_word == hrs_pkg::OPC_RETURN;
  assign is_delayed_return_op = instr_word == hrs_pkg::OPC_RETURN_DLY;
  assign take = instr_valid && state_reg == hrs_pkg::HRS_IDLE;
  // returns under repeat are refused, never executed
  assign repeat_reject = take && in_repeat && (is_ret || is_delayed_return_op);
  assign instr_ready = state_reg == hrs_pkg::HRS_IDLE;

  // memory operand finishes when the port answers; shared single_access_ram adds a cycle
  assign mem_done = mem_ready && !(mem_same_single_access_ram && cnt_reg != 3'h0);

  // stack operation select; one push or pop per cycle at most
  always_comb begin
    op = '0;
    if (state_reg == hrs_pkg::HRS_MEM_WAIT && mem_done) begin
      op.push = 1'b1;
      op.data = mem_rdata;
    end else if (take && is_apush) begin
      op.push = 1'b1;
      op.data = acc[15:0];
    end else if (take && (is_ret || is_delayed_return_op) && !in_repeat) begin
      op.pop = 1'b1;
    end else if (ext_push) begin
      op.push = 1'b1;
      op.data = ext_push_data;
    end
  end

  // memory request is held while waiting for the operand
  always_comb begin
    mem_req = '0;
    if ((take && is_mpush) || state_reg == hrs_pkg::HRS_MEM_WAIT) begin
      mem_req.req = 1'b1;
      mem_req.indirect = instr_word[hrs_pkg::IND_BIT];
      mem_req.dma = instr_word[hrs_pkg::DMA_W-1:0];
      mem_req.arp_load = instr_word[hrs_pkg::IND_BIT] && instr_word[3];
      mem_req.aux_pointer_select = instr_word[hrs_pkg::ARP_W-1:0];
    end
  end

  // sequencer; instr_word must stay stable until instr_ready returns
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= hrs_pkg::HRS_IDLE;
      cnt_reg <= 3'h0;
      dly_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        hrs_pkg::HRS_IDLE: begin
          cnt_reg <= 3'h0;
          if (take && is_mpush) begin
            state_reg <= hrs_pkg::HRS_MEM_WAIT;
            cnt_reg <= hrs_pkg::SINGLE_ACCESS_RAM_SAME_CYCLES - 3'h1;
          end else if (take && !in_repeat && is_ret) begin
            state_reg <= hrs_pkg::HRS_RET_FLUSH;
            cnt_reg <= hrs_pkg::RET_CYCLES - 3'h1;
            dly_reg <= 1'b0;
          end else if (take && !in_repeat && is_delayed_return_op) begin
            state_reg <= hrs_pkg::HRS_RET_SLOT;
            cnt_reg <= hrs_pkg::DLY_SLOTS;
            dly_reg <= 1'b1;
          end
        end
        hrs_pkg::HRS_MEM_WAIT: begin
          if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
          end
          if (mem_done) begin
            state_reg <= hrs_pkg::HRS_IDLE;
          end
        end
        hrs_pkg::HRS_RET_FLUSH: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= hrs_pkg::HRS_IDLE;
          end
        end
        hrs_pkg::HRS_RET_SLOT: begin
          // the two delay-slot words retire through the pipeline
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= hrs_pkg::HRS_IDLE;
          end
        end
        default: begin
          state_reg <= hrs_pkg::HRS_IDLE;
        end
      endcase
    end
  end

  // program counter control is registered so data outputs come from flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_value_reg <= '0;
      pc_load_reg <= 1'b0;
      pc_inc_reg <= 1'b0;
      discard_reg <= 1'b0;
    end else if (clk_en) begin
      pc_inc_reg <= (take && is_apush) ||
        (state_reg == hrs_pkg::HRS_MEM_WAIT && mem_done);
      discard_reg <= take && !in_repeat && is_ret;
      pc_load_reg <= 1'b0;
      if (take && !in_repeat && (is_ret || is_delayed_return_op)) begin
        pc_value_reg <= top;
      end
      if ((state_reg == hrs_pkg::HRS_RET_FLUSH ||
          state_reg == hrs_pkg::HRS_RET_SLOT) && cnt_reg == 3'h1) begin
        pc_load_reg <= 1'b1;
      end
    end
  end

  assign pc_inc = pc_inc_reg;
  assign pc_load = pc_load_reg;
  assign pc_load_value = pc_value_reg;
  assign fetch_discard = discard_reg;
  assign stack_top = top;

  // storage; oldest entry falls off the bottom with no flag
  hrs_array #(.DEPTH(hrs_pkg::DEPTH), .WORD_W(WORD_W)) u_array (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .op(op),
    .top(top)
  );
endmodule
`default_nettype wire

/* verification/hrs_properties.sv */
// concurrent checks on the return stack ports
`timescale 1ns/1ps
`default_nettype none
module hrs_props (
  // clocking and decoder side
  input wire logic clk, sys_rst, clk_en, instr_valid, in_repeat,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready, repeat_reject, ext_push, mem_same_single_access_ram,
  input wire logic [15:0] ext_push_data, mem_rdata,
  input wire logic [15:0] pc_load_value, stack_top,
  input wire logic [31:0] acc,
  // results
  input wire logic mem_ready, pc_inc, pc_load, fetch_discard
);
  logic take, is_acc, is_mem, is_ret, is_dly;
  // decode of an accepted word
  assign take = clk_en && instr_valid && instr_ready;
  assign is_acc = instr_word == hrs_pkg::OPC_ACC_PUSH;
  assign is_mem = instr_word[15:8] == hrs_pkg::OPC_MEM_PUSH[8:1];
  assign is_ret = instr_word == hrs_pkg::OPC_RETURN;
  assign is_dly = instr_word == hrs_pkg::OPC_RETURN_DLY;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // operand wait ends on the ready strobe after which the block is idle
  sequence mem_done;
    (!instr_ready && mem_ready) ##1 instr_ready;
  endsequence
  // busy for three cycles, then ready again
  sequence ret_wait;
    (fetch_discard && !instr_ready) ##1 !instr_ready [*2] ##1 instr_ready;
  endsequence
  acc_push_a: assert property (take && is_acc |=> pc_inc &&
    stack_top == $past(acc[15:0])) else $error("accumulator push wrong");
  mem_push_a: assert property (mem_done |-> pc_inc &&
    stack_top == $past(mem_rdata)) else $error("memory push wrong");
  single_access_ram_wait_a: assert property (take && is_mem && mem_same_single_access_ram
    |=> !pc_inc [*2]) else $error("shared ram push too fast");
  ret_load_a: assert property (take && is_ret && !in_repeat |->
    ##4 pc_load && pc_load_value == $past(stack_top, 4))
    else $error("return load wrong");
  ret_busy_a: assert property (take && is_ret && !in_repeat
    |=> ret_wait) else $error("return timing wrong");
  dly_load_a: assert property (take && is_dly && !in_repeat
    |=> !fetch_discard ##2 pc_load) else $error("delayed return wrong");
  repeat_refuse_a: assert property (take && in_repeat &&
    (is_ret || is_dly) |-> repeat_reject ##1 $stable(stack_top))
    else $error("repeated return not refused");
  ext_push_a: assert property (ext_push && clk_en && take == 1'h0 &&
    !instr_valid |=> stack_top == $past(ext_push_data))
    else $error("external push wrong");
endmodule
bind hardware_return_stack hrs_props hrs_props_i (.*);
`default_nettype wire

/* verification/hrs_dmem.sv */
// data memory model answering operand reads after a set latency
`timescale 1ns/1ps
`default_nettype none
module hrs_dmem (
  input wire logic clk,
  input wire hrs_pkg::hrs_mem_req_t mem_req,
  input wire logic [3:0] lat,
  output var logic mem_ready = 1'h0,
  output var logic [15:0] mem_rdata = 16'h5A5A
);
  logic [3:0] cnt = 4'h0;
  logic hit;
  assign hit = mem_req.req && !mem_ready && cnt == lat;
  // word at an address is that address twice; bus toggles when idle
  always @(posedge clk) begin
    cnt <= (mem_req.req && !mem_ready) ? cnt + 4'h1 : 4'h0;
    mem_ready <= hit;
    mem_rdata <= hit ? {1'h1, mem_req.dma, 1'h0, mem_req.dma} : ~mem_rdata;
  end
endmodule
`default_nettype wire

/* verification/hardware_return_stack_bench.sv */
// self-checking bench for the hardware return stack
`timescale 1ns/1ps
`default_nettype none
module hardware_return_stack_bench;
  logic clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, instr_valid = 1'h0;
  logic in_repeat = 1'h0, ext_push = 1'h0, mem_same_single_access_ram = 1'h0;
  logic instr_ready, repeat_reject, pc_inc, pc_load, fetch_discard;
  logic mem_ready;
  logic [15:0] instr_word = 16'h0, ext_push_data = 16'h0, last;
  logic [15:0] mem_rdata, pc_load_value, stack_top;
  logic [31:0] acc = 32'h0;
  logic [3:0] lat = 4'h0;
  hrs_pkg::hrs_mem_req_t mem_req;
  int err_count = 0, compares = 0, cyc = 0;
  hardware_return_stack hardware_return_stack_i (.*);
  hrs_dmem hrs_dmem_i (.*);
  initial forever #2 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report;
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic f);
    chk({15'h0, f}, 16'h1);
  endtask
  // word presented at a falling edge, taken at the next rising edge
  task automatic issue(input logic [15:0] w, input logic rpt);
    instr_word = w;
    in_repeat = rpt;
    instr_valid = 1'h1;
    @(negedge clk);
  endtask
  task automatic push_acc(input logic [15:0] v);
    acc = {~v, v};
    issue(hrs_pkg::OPC_ACC_PUSH, 1'h0);
    chk(stack_top, v);
    chkf(pc_inc);
  endtask
  task automatic ret(input logic [15:0] w, exp, input int n);
    int k;
    k = 0;
    issue(w, 1'h0);
    instr_valid = 1'h0;
    chkf(fetch_discard == (n == 4));
    while (!pc_load && k < 8) begin
      @(negedge clk);
      k++;
    end
    chk(k[15:0], n[15:0] - 16'h1);
    chk(pc_load_value, exp);
  endtask
  task automatic push_mem(input logic [15:0] w, input logic [3:0] l);
    int k;
    logic [6:0] d;
    k = 0;
    lat = l;
    issue(w, 1'h0);
    instr_valid = 1'h0;
    d = w[6:0];
    chk({3'h0, mem_req}, {4'h1, w[7], d,
      w[7] ? w[3:0] : {1'h0, w[2:0]}});
    while (!pc_inc && k < 20) begin
      @(negedge clk);
      k++;
    end
    last = {1'h1, d, 1'h0, d};
    chk(stack_top, last);
  endtask
  task automatic t_lifo;
    for (int i = 0; i < 10; i++) push_acc(16'hA000 + i[15:0]);
    for (int i = 0; i < 10; i++)
      ret(hrs_pkg::OPC_RETURN, i < 8 ? 16'hA009 - i[15:0] : 16'hA002, 4);
    $display("test lifo done");
  endtask
  task automatic t_mem;
    push_mem({hrs_pkg::OPC_MEM_PUSH, 7'h7F}, 4'h2);
    mem_same_single_access_ram = 1'h1;
    push_mem({hrs_pkg::OPC_MEM_PUSH[8:1], 8'h8D}, 4'h0);
    ret(hrs_pkg::OPC_RETURN, last, 4);
    ret(hrs_pkg::OPC_RETURN, 16'hFF7F, 4);
    $display("test memory push done");
  endtask
  task automatic t_dly_rpt;
    push_acc(16'h1234);
    push_acc(16'h5678);
    issue(hrs_pkg::OPC_RETURN, 1'h1);
    chkf(repeat_reject);
    instr_valid = 1'h0;
    in_repeat = 1'h0;
    chk(stack_top, 16'h5678);
    @(negedge clk);
    ret(hrs_pkg::OPC_RETURN_DLY, 16'h5678, 3);
    ret(hrs_pkg::OPC_RETURN, 16'h1234, 4);
    $display("test delayed and repeat done");
  endtask
  task automatic t_ext;
    // a push offered while the enable is low must leave the stack as it is
    clk_en = 1'h0;
    ext_push_data = 16'hBEEF;
    ext_push = 1'h1;
    @(negedge clk);
    ext_push = 1'h0;
    clk_en = 1'h1;
    chk(stack_top, 16'hA002);
    ext_push_data = 16'hC0DE;
    ext_push = 1'h1;
    @(negedge clk);
    ext_push = 1'h0;
    chk(stack_top, 16'hC0DE);
    ret(hrs_pkg::OPC_RETURN, 16'hC0DE, 4);
    $display("test external push done");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    chk(stack_top, 16'h0);
    chkf(instr_ready);
    t_lifo;
    t_mem;
    t_dly_rpt;
    t_ext;
    final_report;
  end
endmodule
`default_nettype wire
